// *** core/sew_defs.svh ***
`ifndef SEW_DEFS_SVH
`define SEW_DEFS_SVH

`define SEW_ADDR_W       12
`define SEW_PAGE_BYTES   32
`define SEW_PAGE_IDX_W   5
`define SEW_CLK_MHZ      125
`define SEW_TWC_MS       5
`define SEW_TWC_CYCLES   (`SEW_TWC_MS * 1000 * `SEW_CLK_MHZ)
`define SEW_TMR_W        20
`define SEW_DIR_READ     1'b1
`define SEW_BUF_DEPTH    2

`endif

// *** core/sew_pkg.sv ***
`default_nettype none
package sew_pkg;

    typedef enum logic [5:0] {
        SEW_IDLE   = 6'h01,
        SEW_CTRL   = 6'h02,
        SEW_ADDRH  = 6'h04,
        SEW_ADDRL  = 6'h08,
        SEW_DATA   = 6'h10,
        SEW_IGNORE = 6'h20
    } sew_state_e;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  data;
        logic        keep;
    } sew_commit_s;

endpackage
`default_nettype wire

// *** core/sew_buf.sv ***
`timescale 1ns/1ps
`default_nettype none
module sew_buf #(
    parameter int W = 8
) (
    input  wire logic         ref_clk_in,
    input  wire logic         resetn_in,
    input  wire logic         ce_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    // Entry 0 is the head and feeds the outputs straight from flops
    logic [W-1:0] mem_reg [0:1];
    logic         vld_reg [0:1];
    wire          push = in_valid_in & ~vld_reg[1];
    wire          pop  = vld_reg[0] & out_ready_in;

    assign in_ready_out  = ~vld_reg[1];
    assign out_valid_out = vld_reg[0];
    assign out_data_out  = mem_reg[0];

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            vld_reg[0] <= 1'b0;
            vld_reg[1] <= 1'b0;
        end else if (ce_in) begin
            if (pop) begin
                if (vld_reg[1]) begin
                    mem_reg[0] <= mem_reg[1];
                    vld_reg[1] <= 1'b0;
                end else if (push) begin
                    mem_reg[0] <= in_data_in;
                end else begin
                    vld_reg[0] <= 1'b0;
                end
            end else if (push) begin
                if (!vld_reg[0]) begin
                    mem_reg[0] <= in_data_in;
                    vld_reg[0] <= 1'b1;
                end else begin
                    mem_reg[1] <= in_data_in;
                    vld_reg[1] <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** core/sew_slave.sv ***
// Notes on behaviour
// - Bus is idle while data and clock lines both stay high.
// - Data falling while clock high is a Start; it begins a command.
// - Data rising while clock high is a Stop; it ends the operation.
// - Data changes only while clock low; one clock pulse per bit.
// - Addressed receiver acknowledges every byte on a ninth clock pulse.
// - Acknowledge holds data low through the whole high phase.
// - On reads the master withholds the last acknowledge; device releases data.
// - First byte is type code, three chip-select bits, then direction.
// - Respond only when chip-select bits equal the chip-select pin levels.
// - Matching control byte is acknowledged; direction one reads, zero writes.
// - Two address bytes follow, high first; only twelve low bits kept.
// - Stop after an acknowledged data byte starts the internal write.
// - No acknowledge at all while an internal write runs.
// - Internal write cycle lasts at most five milliseconds.
// - Write-protected writes are acknowledged, then skipped; ready at once.
// - After a byte write the pointer holds the next address.
// - Up to 31 further bytes go to a page buffer, committed at Stop.
// - Each data byte bumps only the low five pointer bits.
// - More than 32 bytes wrap and overwrite; last 32 are kept.
// - Untouched bytes of a partly written page are refreshed unchanged.
// - Write-protect is sampled at Stop and covers the whole array.
`include "sew_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sew_slave #(
    // Device type code; value arbitrary
    parameter logic [3:0] DEV_TYPE     = 4'h5,
    parameter int         WRITE_CYCLES = `SEW_TWC_CYCLES
) (
    input  wire logic                ref_clk_in,
    input  wire logic                resetn_in,
    input  wire logic                ce_in,
    input  wire logic                scl_in,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe_out,
    input  wire logic                wp_in,
    input  wire logic                chip_select_in0,
    input  wire logic                chip_select_in1,
    input  wire logic                chip_select_in2,
    output logic                     busy_out,
    output logic                     read_start_out,
    output logic [`SEW_ADDR_W-1:0]   addr_ptr_out,
    output logic                     wr_valid_out,
    input  wire logic                wr_ready_in,
    output sew_pkg::sew_commit_s     wr_data_out
);
    localparam int CW = $bits(sew_pkg::sew_commit_s);

    // Pin synchronisers: scl, sda, wp, chip selects
    logic [5:0] pin_meta_reg;
    logic [5:0] pin_sync_reg;
    logic [5:0] pin_prev_reg;
    wire  [5:0] pin_raw = {chip_select_in2, chip_select_in1, chip_select_in0,
                           wp_in, sda_in, scl_in};

    wire       scl_s = pin_sync_reg[0];
    wire       sda_s = pin_sync_reg[1];
    wire       wp_s  = pin_sync_reg[2];
    wire [2:0] cs_s  = pin_sync_reg[5:3];
    wire       scl_p = pin_prev_reg[0];
    wire       sda_p = pin_prev_reg[1];

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_meta_reg <= 6'h03;
            pin_sync_reg <= 6'h03;
            pin_prev_reg <= 6'h03;
        end else if (ce_in) begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Bus conditions seen on the synchronised lines
    wire start_det = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_det  = scl_s & scl_p & ~sda_p & sda_s;
    wire scl_rise  = scl_s & ~scl_p;
    wire scl_fall  = ~scl_s & scl_p;

    sew_pkg::sew_state_e state_reg;
    sew_pkg::sew_state_e state_next;
    logic [3:0]              bit_cnt_reg;
    logic                    ack_phase_reg;
    logic [7:0]              shift_reg;
    logic                    ack_reg;
    logic                    busy_reg;
    logic                    got_data_reg;
    logic                    rd_start_reg;
    logic [3:0]              addr_hi_reg;
    logic [`SEW_ADDR_W-1:0]  ptr_reg;
    logic [`SEW_ADDR_W-1:0]  ptr_next;

    // Byte ends on the fall after the eighth rise; the ninth pulse is the ack slot
    wire byte_done = scl_fall & (bit_cnt_reg == 4'h8) & ~ack_phase_reg;
    wire ack_end   = scl_fall & ack_phase_reg;

    wire ctrl_match = (shift_reg[7:4] == DEV_TYPE)
                    & (shift_reg[3:1] == cs_s)
                    & ~busy_reg;
    wire in_ctrl  = (state_reg == sew_pkg::SEW_CTRL);
    wire in_addrh = (state_reg == sew_pkg::SEW_ADDRH);
    wire in_addrl = (state_reg == sew_pkg::SEW_ADDRL);
    wire in_data  = (state_reg == sew_pkg::SEW_DATA);
    wire ack_ok   = (in_ctrl & ctrl_match) | in_addrh | in_addrl | in_data;
    wire rd_sel   = byte_done & in_ctrl & ctrl_match & (shift_reg[0] == `SEW_DIR_READ);
    wire addrl_done = byte_done & in_addrl;
    wire data_done  = byte_done & in_data;
    wire commit_go  = stop_det & in_data & got_data_reg & ~busy_reg & ~wp_s;

    always_comb begin
        state_next = state_reg;
        if (start_det) begin
            state_next = sew_pkg::SEW_CTRL;
        end else if (stop_det) begin
            state_next = sew_pkg::SEW_IDLE;
        end else if (byte_done) begin
            unique case (state_reg)
                sew_pkg::SEW_CTRL: begin
                    if (ctrl_match && shift_reg[0] != `SEW_DIR_READ) begin
                        state_next = sew_pkg::SEW_ADDRH;
                    end else begin
                        // Reads belong to the read logic; stay off the line
                        state_next = sew_pkg::SEW_IGNORE;
                    end
                end
                sew_pkg::SEW_ADDRH: state_next = sew_pkg::SEW_ADDRL;
                sew_pkg::SEW_ADDRL: state_next = sew_pkg::SEW_DATA;
                sew_pkg::SEW_DATA:  state_next = sew_pkg::SEW_DATA;
                sew_pkg::SEW_IDLE:  state_next = sew_pkg::SEW_IDLE;
                sew_pkg::SEW_IGNORE: state_next = sew_pkg::SEW_IGNORE;
                default: state_next = sew_pkg::SEW_IDLE;
            endcase
        end
    end

    assign ptr_next = addrl_done ? {addr_hi_reg, shift_reg} :
                      data_done  ? {ptr_reg[11:5], ptr_reg[4:0] + 5'h01} :
                      ptr_reg;

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= sew_pkg::SEW_IDLE;
            ptr_reg   <= '0;
        end else if (ce_in) begin
            state_reg <= state_next;
            ptr_reg   <= ptr_next;
        end
    end

    // Bit counting and shifting on SCL edges
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bit_cnt_reg   <= 4'h0;
            ack_phase_reg <= 1'b0;
            shift_reg     <= 8'h00;
        end else if (ce_in) begin
            if (start_det || stop_det) begin
                bit_cnt_reg   <= 4'h0;
                ack_phase_reg <= 1'b0;
            end else if (scl_rise && bit_cnt_reg != 4'h8) begin
                shift_reg   <= {shift_reg[6:0], sda_s};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (byte_done) begin
                ack_phase_reg <= 1'b1;
            end else if (ack_end) begin
                ack_phase_reg <= 1'b0;
                bit_cnt_reg   <= 4'h0;
            end
        end
    end

    // Ack drive: set on the fall after the byte, released on the next fall
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_reg      <= 1'b0;
            got_data_reg <= 1'b0;
            rd_start_reg <= 1'b0;
            addr_hi_reg  <= 4'h0;
        end else if (ce_in) begin
            rd_start_reg <= rd_sel;
            if (start_det || stop_det || ack_end) begin
                ack_reg <= 1'b0;
            end else if (byte_done) begin
                ack_reg <= ack_ok;
            end
            if (start_det) begin
                got_data_reg <= 1'b0;
            end else if (data_done) begin
                got_data_reg <= 1'b1;
            end
            if (byte_done && in_addrh) begin
                addr_hi_reg <= shift_reg[3:0];
            end
        end
    end

    // Page buffer, indexed by the low pointer bits
    logic [7:0]                  page_mem [0:`SEW_PAGE_BYTES-1];
    logic [`SEW_PAGE_BYTES-1:0]  page_fill_reg;

    for (genvar i = 0; i < `SEW_PAGE_BYTES; i++) begin : g_page
        wire hit = data_done & (ptr_reg[4:0] == 5'(i));
        always_ff @(posedge ref_clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                page_mem[i]      <= 8'h00;
                page_fill_reg[i] <= 1'b0;
            end else if (ce_in) begin
                if (addrl_done) begin
                    page_fill_reg[i] <= 1'b0;
                end else if (hit) begin
                    page_mem[i]      <= shift_reg;
                    page_fill_reg[i] <= 1'b1;
                end
            end
        end
    end

    // Internal write: stream the whole page out while the cycle timer runs; done when both finish
    logic [5:0]            commit_idx_reg;
    logic [`SEW_TMR_W-1:0] tmr_reg;
    logic                  buf_in_ready;
    logic                  buf_out_valid;
    logic [CW-1:0]         buf_out_data;
    sew_pkg::sew_commit_s  push_word;

    wire [4:0] cidx      = commit_idx_reg[4:0];
    wire       push_vld  = busy_reg & ~commit_idx_reg[5];
    wire       push_take = push_vld & buf_in_ready;
    wire       cycle_end = busy_reg & (tmr_reg == '0) & commit_idx_reg[5] & ~buf_out_valid;

    assign push_word.addr = {ptr_reg[11:5], cidx};
    assign push_word.data = page_mem[cidx];
    assign push_word.keep = ~page_fill_reg[cidx];

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_reg       <= 1'b0;
            commit_idx_reg <= 6'h20;
            tmr_reg        <= '0;
        end else if (ce_in) begin
            if (commit_go) begin
                busy_reg       <= 1'b1;
                commit_idx_reg <= 6'h00;
                tmr_reg        <= `SEW_TMR_W'(WRITE_CYCLES - 1);
            end else begin
                if (push_take) begin
                    commit_idx_reg <= commit_idx_reg + 6'h01;
                end
                if (tmr_reg != '0) begin
                    tmr_reg <= tmr_reg - `SEW_TMR_W'(1);
                end
                if (cycle_end) begin
                    busy_reg <= 1'b0;
                end
            end
        end
    end

    sew_buf #(
        .W (CW)
    ) u_buf (
        .ref_clk_in    (ref_clk_in),
        .resetn_in     (resetn_in),
        .ce_in         (ce_in),
        .in_valid_in   (push_vld),
        .in_ready_out  (buf_in_ready),
        .in_data_in    (push_word),
        .out_valid_out (buf_out_valid),
        .out_ready_in  (wr_ready_in),
        .out_data_out  (buf_out_data)
    );

    logic sda_drv_reg;
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sda_drv_reg <= 1'b0;
        end else if (ce_in) begin
            sda_drv_reg <= 1'b0;
        end
    end

    assign sda_out        = sda_drv_reg;
    assign sda_oe_out     = ack_reg;
    assign busy_out       = busy_reg;
    assign read_start_out = rd_start_reg;
    assign addr_ptr_out   = ptr_reg;
    assign wr_valid_out   = buf_out_valid;
    assign wr_data_out    = sew_pkg::sew_commit_s'(buf_out_data);

    property p_start;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && start_det |=> state_reg == sew_pkg::SEW_CTRL && bit_cnt_reg == 4'h0;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_stop;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && stop_det && !start_det |=> state_reg == sew_pkg::SEW_IDLE && !sda_oe_out;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");

    property p_busy_quiet;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        busy_reg |-> !sda_oe_out;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("ack during write");

    property p_ack_low_clk;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        $rose(sda_oe_out) |-> !scl_s ##1 sda_oe_out;
    endproperty
    a_ack_low_clk: assert property (p_ack_low_clk) else $error("ack not in low phase");

    property p_cs_mismatch;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && byte_done && in_ctrl && shift_reg[3:1] != cs_s |=> !sda_oe_out;
    endproperty
    a_cs_mismatch: assert property (p_cs_mismatch) else $error("ack on wrong select");

    property p_ptr_wrap;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && data_done |=> ptr_reg[11:5] == $past(ptr_reg[11:5])
            && ptr_reg[4:0] == 5'($past(ptr_reg[4:0]) + 5'h01);
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer step wrong");

    property p_addr_load;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && addrl_done |=> ptr_reg == {$past(addr_hi_reg), $past(shift_reg)};
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address load wrong");

    property p_wp_skip;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && stop_det && in_data && wp_s && !busy_reg |=> !busy_reg;
    endproperty
    a_wp_skip: assert property (p_wp_skip) else $error("protected write ran");

    property p_commit;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && commit_go |=> busy_reg && commit_idx_reg == 6'h00;
    endproperty
    a_commit: assert property (p_commit) else $error("write cycle not started");

    property p_read_sel;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && rd_sel |=> read_start_out && sda_oe_out ##1 !read_start_out;
    endproperty
    a_read_sel: assert property (p_read_sel) else $error("read select wrong");
endmodule
`default_nettype wire

// *** dv/sew_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module sew_master (
    output logic      scl_out,
    output logic      sda_out,
    input  wire logic sda_in
);
    localparam realtime Q = 31.25;

    // Both lines released while no frame runs
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    task automatic start_cond();
        sda_out = 1'b1;
        #(Q);
        scl_out = 1'b1;
        #(Q);
        sda_out = 1'b0;
        #(Q);
        scl_out = 1'b0;
        #(Q);
    endtask

    task automatic clock_bit(input logic b, output logic seen);
        sda_out = b;
        #(Q);
        scl_out = 1'b1;
        #(Q);
        seen = sda_in;
        #(Q);
        scl_out = 1'b0;
        #(Q);
    endtask

    // Ninth pulse with the line released; low means acknowledged
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic stop_cond();
        sda_out = 1'b0;
        #(Q);
        scl_out = 1'b1;
        #(Q);
        sda_out = 1'b1;
        #(2 * Q);
    endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                 ref_clk_in;
    logic                 resetn_in   = 1'b0;
    logic                 wp_in       = 1'b0;
    logic                 wr_ready_in = 1'b1;
    logic                 stall_en    = 1'b0;
    logic                 ce          = 1'b1;
    logic [2:0]           cs          = 3'b101;
    logic                 scl_w;
    logic                 m_sda;
    logic                 sda_w;
    logic                 sda_drv;
    logic                 sda_oe;
    logic                 busy;
    logic                 rd_start;
    logic                 wr_valid;
    logic [11:0]          ptr;
    sew_pkg::sew_commit_s wr_word;
    logic [7:0]           mem [0:4095];
    int                   err_total = 0;
    int                   n_tests   = 0;
    int                   cyc       = 0;
    int                   n_words   = 0;
    int                   n_kept    = 0;
    int                   n_rd      = 0;

    // Open drain with pull-up: low if either party pulls
    assign sda_w = m_sda & (sda_oe ? sda_drv : 1'b1);

    sew_master u_mst (
        .scl_out (scl_w),
        .sda_out (m_sda),
        .sda_in  (sda_w)
    );

    sew_slave #(.DEV_TYPE(4'h5), .WRITE_CYCLES(600)) DUT (
        .ref_clk_in      (ref_clk_in),
        .resetn_in       (resetn_in),
        .ce_in           (ce),
        .scl_in          (scl_w),
        .sda_in          (sda_w),
        .sda_out         (sda_drv),
        .sda_oe_out      (sda_oe),
        .wp_in           (wp_in),
        .chip_select_in0 (cs[0]),
        .chip_select_in1 (cs[1]),
        .chip_select_in2 (cs[2]),
        .busy_out        (busy),
        .read_start_out  (rd_start),
        .addr_ptr_out    (ptr),
        .wr_valid_out    (wr_valid),
        .wr_ready_in     (wr_ready_in),
        .wr_data_out     (wr_word)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    // Array stand-in and cycle watchdog
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (rd_start === 1'b1) n_rd <= n_rd + 1;
        if (wr_valid === 1'b1 && wr_ready_in && ce) begin
            n_words <= n_words + 1;
            if (wr_word.keep) n_kept <= n_kept + 1;
            else mem[wr_word.addr] <= wr_word.data;
        end
        if (cyc == 60000) begin
            err_total++;
            tally_and_finish();
        end
    end

    always @(negedge ref_clk_in) wr_ready_in <= stall_en ? cyc[2] : 1'b1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic write_cmd(input logic [15:0] a16, input int n, input logic [7:0] d0);
        logic ack;
        u_mst.start_cond();
        u_mst.send_byte(8'h5a, ack);
        check(ack, 1'b1);
        u_mst.send_byte(a16[15:8], ack);
        check(ack, 1'b1);
        u_mst.send_byte(a16[7:0], ack);
        check(ack, 1'b1);
        for (int k = 0; k < n; k++) begin
            u_mst.send_byte(d0 + 8'(k), ack);
            check(ack, 1'b1);
        end
        u_mst.stop_cond();
    endtask

    task automatic wait_idle();
        int t;
        t = 0;
        while (busy !== 1'b0 && t < 2000) begin
            @(posedge ref_clk_in);
            t++;
        end
        check(busy, 1'b0);
    endtask

    task automatic t_select();
        logic ack;
        int   r0;
        r0 = n_rd;
        u_mst.start_cond();
        u_mst.send_byte(8'h6a, ack);
        check(ack, 1'b0);
        u_mst.start_cond();
        u_mst.send_byte(8'h58, ack);
        check(ack, 1'b0);
        u_mst.start_cond();
        u_mst.send_byte(8'h5b, ack);
        check(ack, 1'b1);
        u_mst.stop_cond();
        check(n_rd - r0, 1);
    endtask

    task automatic t_byte();
        logic ack;
        int   w0;
        int   k0;
        w0 = n_words;
        k0 = n_kept;
        write_cmd(16'hf345, 1, 8'ha7);
        repeat (8) @(posedge ref_clk_in);
        check(busy, 1'b1);
        check(ptr, 12'h346);
        // Clock enable low freezes the cycle timer and the word stream
        @(negedge ref_clk_in) ce = 1'b0;
        repeat (700) @(posedge ref_clk_in);
        check(busy, 1'b1);
        @(negedge ref_clk_in) ce = 1'b1;
        // Protect raised after Stop must not cancel the running cycle
        @(negedge ref_clk_in) wp_in = 1'b1;
        u_mst.start_cond();
        u_mst.send_byte(8'h5a, ack);
        check(ack, 1'b0);
        u_mst.stop_cond();
        wait_idle();
        check(n_words - w0, 32);
        check(n_kept - k0, 31);
        check(mem[12'h345], 8'ha7);
        @(negedge ref_clk_in) wp_in = 1'b0;
    endtask

    task automatic t_page();
        int k;
        int k0;
        k0 = n_kept;
        stall_en = 1'b1;
        write_cmd(16'h005e, 35, 8'h10);
        repeat (8) @(posedge ref_clk_in);
        check(ptr, 12'h041);
        wait_idle();
        for (int i = 0; i < 32; i++) begin
            k = (i + 2) % 32;
            if (k < 3) k = k + 32;
            check(mem[12'h040 + 12'(i)], 8'h10 + 8'(k));
        end
        check(n_kept - k0, 0);
        stall_en = 1'b0;
    endtask

    task automatic t_wp();
        logic ack;
        int   w0;
        w0 = n_words;
        @(negedge ref_clk_in) wp_in = 1'b1;
        write_cmd(16'h0100, 2, 8'h33);
        @(negedge ref_clk_in) wp_in = 1'b0;
        repeat (8) @(posedge ref_clk_in);
        check(busy, 1'b0);
        u_mst.start_cond();
        u_mst.send_byte(8'h5a, ack);
        check(ack, 1'b1);
        u_mst.stop_cond();
        repeat (8) @(posedge ref_clk_in);
        check(n_words - w0, 0);
    endtask

    initial begin
        for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
        repeat (10) @(posedge ref_clk_in);
        @(negedge ref_clk_in) resetn_in = 1'b1;
        repeat (4) @(posedge ref_clk_in);
        t_select();
        t_byte();
        t_page();
        t_wp();
        tally_and_finish();
    end
endmodule
`default_nettype wire
